//--- design/ssm_pkg.sv
// Purpose: Constants and types for the clocked serial port block.
// Assumes: AXI4-Lite access, 32-bit data, one aligned word per register.
// Notes: Only synchronous (clocked) operation is modelled.
package ssm_pkg;
    localparam logic [5:0] ADR_BAUD = 6'h00;
    localparam logic [5:0] ADR_IEN = 6'h04;
    localparam logic [5:0] ADR_IFLG = 6'h08;
    localparam logic [5:0] ADR_RCSC = 6'h0c;
    localparam logic [5:0] ADR_DIVL = 6'h10;
    localparam logic [5:0] ADR_DIVH = 6'h14;
    localparam logic [5:0] ADR_TXB = 6'h18;
    localparam logic [5:0] ADR_TXSC = 6'h1c;
    localparam logic [5:0] ADR_RXT = 6'h20;
    localparam logic [5:0] ADR_ICTL = 6'h24;
    localparam int B_CLOCK_POLARITY_SELECT = 4;
    localparam int B_WIDE_BAUD_COUNTER_SELECT = 3;
    localparam int B_RXI = 5;
    localparam int B_TXI = 4;
    localparam int B_SERIAL_PORT_ENABLE = 7;
    localparam int B_RX9 = 6;
    localparam int B_SINGLE_RECEIVE_ENABLE = 5;
    localparam int B_CONTINUOUS_RECEIVE_ENABLE = 4;
    localparam int B_OVERRUN_ERROR_FLAG = 1;
    localparam int B_RECEIVE_NINTH_BIT_VALUE = 0;
    localparam int B_CLOCK_SOURCE_MASTER = 7;
    localparam int B_TX9 = 6;
    localparam int B_TRANSMIT_ENABLE = 5;
    localparam int B_SYNC = 4;
    localparam int B_HIGH_SPEED_BAUD_SELECT = 2;
    localparam int B_TRMT = 1;
    localparam int B_TRANSMIT_NINTH_BIT_VALUE = 0;
    localparam int B_PERIPHERAL_IRQ_ENABLE = 0;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    localparam logic [3:0] LAST8 = 4'h7;
    localparam logic [3:0] LAST9 = 4'h8;
    localparam logic [1:0] FIFO_FULL = 2'h2;

    typedef struct packed {
        logic serial_port_enable, rx9, single_receive_enable, continuous_receive_enable;
        logic clock_source_master, tx9, transmit_enable, sync, high_speed_baud_select, transmit_ninth_bit_value;
        logic clock_polarity_select, wide_baud_counter_select, receive_irq_enable, transmit_irq_enable, peripheral_irq_enable;
    } ssm_ctrl_t;

    localparam ssm_ctrl_t CTRL_RST = '0;
endpackage

//--- design/ssm_top.sv
// Purpose: Clocked serial port, master or slave, with register access.
// Assumes: aclk 200 MHz; link clock is sampled, never used as a clock.
// Notes: Line inputs pass two flops, so slave edges lag by 2 cycles.
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ssm_top import ssm_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic data_line_i,
    output logic data_line_o,
    output logic data_line_oe,
    input wire logic clock_line_i,
    output logic clock_line_o,
    output logic clock_line_oe,
    output logic wake_o
);
    ssm_ctrl_t ctrl_ff, nxt_ctrl;
    logic [7:0] divl_ff, divh_ff;
    logic bvalid_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic [7:0] rb;
    logic [15:0] brg_ff;
    logic [1:0] pre_ff;
    logic phase_ff, ckout_ff;
    logic dl_s1, dl_s2, ck_s1, ck_s2, ck_s3;
    logic [3:0] bit_ff;
    logic [8:0] tsr_ff, thr_ff, rsr_ff;
    logic busy_ff, thrf_ff, dout_ff, overrun_error_flag_ff;
    logic [8:0] fifo_ff [2];
    logic [1:0] cnt_ff;

    // Bus decode; address and data are taken together in one cycle.
    wire wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
    wire rd_go = s_axi_arvalid & ~rvalid_ff;
    wire [5:0] wa = {s_axi_awaddr[5:2], 2'h0};
    wire [5:0] ra = {s_axi_araddr[5:2], 2'h0};
    wire wa_ok = wa <= ADR_ICTL;
    wire ra_ok = ra <= ADR_ICTL;
    wire wr_lo = wr_go & s_axi_wstrb[0];
    wire [7:0] wd = s_axi_wdata[7:0];
    wire wr_thr = wr_lo & (wa == ADR_TXB);
    wire rd_rxt = rd_go & (ra == ADR_RXT);
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;

    // Mode decode; receive selection overrides transmit.
    wire en = ctrl_ff.serial_port_enable & ctrl_ff.sync;
    wire master = en & ctrl_ff.clock_source_master;
    wire slave = en & ~ctrl_ff.clock_source_master;
    wire rx_mode = en & (ctrl_ff.single_receive_enable | ctrl_ff.continuous_receive_enable);
    wire rx_run = rx_mode & ~overrun_error_flag_ff;
    wire tx_mode = en & ctrl_ff.transmit_enable & ~rx_mode;
    wire tx_act = tx_mode & busy_ff;
    wire run_m = master & (tx_act | rx_run);
    wire nine = rx_mode ? ctrl_ff.rx9 : ctrl_ff.tx9;
    wire [3:0] last = nine ? LAST9 : LAST8;
    wire din = dl_s2;

    // Baud divisor; an idle generator stays loaded so the first half
    // period is a full one.
    wire [15:0] div = ctrl_ff.wide_baud_counter_select ? {divh_ff, divl_ff} : {8'h00, divl_ff};
    wire fast = ctrl_ff.high_speed_baud_select | ctrl_ff.wide_baud_counter_select;
    wire tick = run_m & (brg_ff == 16'h0000) & (fast | (&pre_ff));
    wire m_lead = tick & ~phase_ff;
    wire m_trail = tick & phase_ff;

    // Slave edges from the synchronised clock line.
    wire ck_chg = ck_s2 ^ ck_s3;
    wire s_lead = slave & ck_chg & (ck_s2 ^ ctrl_ff.clock_polarity_select);
    wire s_trail = slave & ck_chg & ~(ck_s2 ^ ctrl_ff.clock_polarity_select);
    wire lead = master ? m_lead : s_lead;
    wire trail = master ? m_trail : s_trail;
    wire xfer_on = tx_act | rx_run;
    wire at_last = bit_ff == last;
    wire tx_done = tx_act & trail & at_last;
    wire char_done = rx_run & trail & at_last;

    // Transmit holding and shifter moves.
    wire load_thr = tx_mode & ~busy_ff & thrf_ff;
    wire load_wr = tx_mode & ~busy_ff & ~thrf_ff & wr_thr;
    wire [8:0] wr_char = {ctrl_ff.tx9 & ctrl_ff.transmit_ninth_bit_value, wd};
    wire transmit_buffer_empty_flag = ~thrf_ff;

    // Receive assembly and FIFO control.
    wire [8:0] rx_char = ctrl_ff.rx9 ? {din, rsr_ff[7:0]}
                                     : {1'b0, din, rsr_ff[6:0]};
    wire pop = rd_rxt & (cnt_ff != 2'h0);
    wire push = char_done & ((cnt_ff != FIFO_FULL) | pop);
    wire ovr = char_done & ~push;
    wire [1:0] wi = cnt_ff - {1'b0, pop};
    wire receive_flag = cnt_ff != 2'h0;
    wire continuous_receive_enable_fall = ctrl_ff.continuous_receive_enable & ~nxt_ctrl.continuous_receive_enable;
    wire overrun_error_flag_clr = ~ctrl_ff.serial_port_enable | continuous_receive_enable_fall
                  | (~ctrl_ff.continuous_receive_enable & rd_rxt);

    // Pin drivers.
    assign data_line_oe = tx_mode;
    assign clock_line_oe = master & (tx_mode | rx_mode);
    assign data_line_o = dout_ff;
    assign clock_line_o = ckout_ff;
    assign wake_o = ctrl_ff.peripheral_irq_enable & ((transmit_buffer_empty_flag & ctrl_ff.transmit_irq_enable)
                  | (receive_flag & ctrl_ff.receive_irq_enable));

    // Control bits; a software write lands after the hardware clear.
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (char_done) begin
            nxt_ctrl.single_receive_enable = 1'b0;
        end
        if (wr_lo && wa == ADR_BAUD) begin
            nxt_ctrl.clock_polarity_select = wd[B_CLOCK_POLARITY_SELECT];
            nxt_ctrl.wide_baud_counter_select = wd[B_WIDE_BAUD_COUNTER_SELECT];
        end
        if (wr_lo && wa == ADR_IEN) begin
            nxt_ctrl.receive_irq_enable = wd[B_RXI];
            nxt_ctrl.transmit_irq_enable = wd[B_TXI];
        end
        if (wr_lo && wa == ADR_RCSC) begin
            nxt_ctrl.serial_port_enable = wd[B_SERIAL_PORT_ENABLE];
            nxt_ctrl.rx9 = wd[B_RX9];
            nxt_ctrl.single_receive_enable = wd[B_SINGLE_RECEIVE_ENABLE];
            nxt_ctrl.continuous_receive_enable = wd[B_CONTINUOUS_RECEIVE_ENABLE];
        end
        if (wr_lo && wa == ADR_TXSC) begin
            nxt_ctrl.clock_source_master = wd[B_CLOCK_SOURCE_MASTER];
            nxt_ctrl.tx9 = wd[B_TX9];
            nxt_ctrl.transmit_enable = wd[B_TRANSMIT_ENABLE];
            nxt_ctrl.sync = wd[B_SYNC];
            nxt_ctrl.high_speed_baud_select = wd[B_HIGH_SPEED_BAUD_SELECT];
            nxt_ctrl.transmit_ninth_bit_value = wd[B_TRANSMIT_NINTH_BIT_VALUE];
        end
        if (wr_lo && wa == ADR_ICTL) begin
            nxt_ctrl.peripheral_irq_enable = wd[B_PERIPHERAL_IRQ_ENABLE];
        end
    end

    // Read mux; unlisted bits read as zero.
    always_comb begin
        rb = 8'h00;
        unique case (ra)
            ADR_BAUD: begin
                rb[B_CLOCK_POLARITY_SELECT] = ctrl_ff.clock_polarity_select;
                rb[B_WIDE_BAUD_COUNTER_SELECT] = ctrl_ff.wide_baud_counter_select;
            end
            ADR_IEN: begin
                rb[B_RXI] = ctrl_ff.receive_irq_enable;
                rb[B_TXI] = ctrl_ff.transmit_irq_enable;
            end
            ADR_IFLG: begin
                rb[B_RXI] = receive_flag;
                rb[B_TXI] = transmit_buffer_empty_flag;
            end
            ADR_RCSC: begin
                rb[B_SERIAL_PORT_ENABLE] = ctrl_ff.serial_port_enable;
                rb[B_RX9] = ctrl_ff.rx9;
                rb[B_SINGLE_RECEIVE_ENABLE] = ctrl_ff.single_receive_enable;
                rb[B_CONTINUOUS_RECEIVE_ENABLE] = ctrl_ff.continuous_receive_enable;
                rb[B_OVERRUN_ERROR_FLAG] = overrun_error_flag_ff;
                rb[B_RECEIVE_NINTH_BIT_VALUE] = fifo_ff[0][8];
            end
            ADR_DIVL: rb = divl_ff;
            ADR_DIVH: rb = divh_ff;
            ADR_TXSC: begin
                rb[B_CLOCK_SOURCE_MASTER] = ctrl_ff.clock_source_master;
                rb[B_TX9] = ctrl_ff.tx9;
                rb[B_TRANSMIT_ENABLE] = ctrl_ff.transmit_enable;
                rb[B_SYNC] = ctrl_ff.sync;
                rb[B_HIGH_SPEED_BAUD_SELECT] = ctrl_ff.high_speed_baud_select;
                rb[B_TRMT] = ~busy_ff;
                rb[B_TRANSMIT_NINTH_BIT_VALUE] = ctrl_ff.transmit_ninth_bit_value;
            end
            ADR_RXT: rb = fifo_ff[0][7:0];
            ADR_ICTL: rb[B_PERIPHERAL_IRQ_ENABLE] = ctrl_ff.peripheral_irq_enable;
            default: rb = 8'h00;
        endcase
    end

    // Bus responses and software registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= CTRL_RST;
            divl_ff <= 8'h00;
            divh_ff <= 8'h00;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OK;
            rvalid_ff <= 1'b0;
            rresp_ff <= RESP_OK;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ctrl_ff <= nxt_ctrl;
            if (wr_lo && wa == ADR_DIVL) divl_ff <= wd;
            if (wr_lo && wa == ADR_DIVH) divh_ff <= wd;
            if (wr_go) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wa_ok ? RESP_OK : RESP_ERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
            if (rd_go) begin
                rvalid_ff <= 1'b1;
                rresp_ff <= ra_ok ? RESP_OK : RESP_ERR;
                rdata_ff <= {24'h00_0000, rb};
            end else if (s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // Line synchronisers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {dl_s1, dl_s2} <= 2'h0;
            {ck_s1, ck_s2, ck_s3} <= 3'h0;
        end else begin
            dl_s1 <= data_line_i;
            dl_s2 <= dl_s1;
            ck_s1 <= clock_line_i;
            ck_s2 <= ck_s1;
            ck_s3 <= ck_s2;
        end
    end

    // Master clock: two ticks per bit, so each half period is one divisor
    // interval, or four with high speed and wide baud both off. Stopping drops the line to idle at once.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            brg_ff <= 16'h0000;
            pre_ff <= 2'h0;
            phase_ff <= 1'b0;
            ckout_ff <= 1'b0;
        end else begin
            if (!run_m) begin
                brg_ff <= div;
                pre_ff <= 2'h0;
                phase_ff <= 1'b0;
            end else if (brg_ff == 16'h0000) begin
                brg_ff <= div;
                pre_ff <= pre_ff + 2'h1;
                if (tick) phase_ff <= ~phase_ff;
            end else begin
                brg_ff <= brg_ff - 16'h0001;
            end
            ckout_ff <= ctrl_ff.clock_polarity_select ^ (run_m & (phase_ff ^ tick));
        end
    end

    // Bit counter shared by both directions; the port is half duplex.
    always_ff @(posedge aclk) begin
        if (!aresetn || !xfer_on) begin
            bit_ff <= 4'h0;
        end else if (trail) begin
            bit_ff <= at_last ? 4'h0 : bit_ff + 4'h1;
        end
    end

    // Transmit path.
    always_ff @(posedge aclk) begin
        if (!aresetn || !ctrl_ff.serial_port_enable) begin
            busy_ff <= 1'b0;
            thrf_ff <= 1'b0;
            tsr_ff <= 9'h000;
            thr_ff <= 9'h000;
            dout_ff <= 1'b0;
        end else begin
            if (load_thr) begin
                tsr_ff <= thr_ff;
                busy_ff <= 1'b1;
            end else if (load_wr) begin
                tsr_ff <= wr_char;
                busy_ff <= 1'b1;
            end else if (tx_done) begin
                busy_ff <= 1'b0;
            end
            thrf_ff <= (thrf_ff & ~load_thr) | (wr_thr & ~load_wr);
            if (wr_thr && !load_wr) thr_ff <= wr_char;
            if (tx_act && lead) dout_ff <= tsr_ff[bit_ff];
        end
    end

    // Receive path: the shifter samples on trailing edges only.
    always_ff @(posedge aclk) begin
        if (!aresetn || !ctrl_ff.serial_port_enable) begin
            rsr_ff <= 9'h000;
            cnt_ff <= 2'h0;
            fifo_ff[0] <= 9'h000;
            fifo_ff[1] <= 9'h000;
        end else begin
            if (rx_run && trail) rsr_ff[bit_ff] <= din;
            if (pop) fifo_ff[0] <= fifo_ff[1];
            if (push && wi == 2'h0) fifo_ff[0] <= rx_char;
            if (push && wi == 2'h1) fifo_ff[1] <= rx_char;
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end

    // Overrun flag; a new overrun wins over a clear in the same cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overrun_error_flag_ff <= 1'b0;
        end else if (ovr) begin
            overrun_error_flag_ff <= 1'b1;
        end else if (overrun_error_flag_clr) begin
            overrun_error_flag_ff <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    rx_drv_off_a: assert property (rx_mode |-> !data_line_oe)
        else $error("data driver on during receive");
    slv_ck_off_a: assert property (slave |-> !clock_line_oe)
        else $error("clock driver on in slave mode");
    single_receive_enable_clr_a: assert property (char_done && !(wr_lo && wa == ADR_RCSC)
        |=> !ctrl_ff.single_receive_enable)
        else $error("single receive not cleared");
    continuous_receive_enable_stop_a: assert property (master && !ctrl_ff.single_receive_enable && continuous_receive_enable_fall
        |=> ##1 bit_ff == 4'h0 && clock_line_o == ctrl_ff.clock_polarity_select)
        else $error("clock not stopped on cancel");
    receive_flag_set_a: assert property (push |=> receive_flag [*1] ##0 cnt_ff != 2'h0)
        else $error("receive flag not raised");
    ovr_keep_a: assert property (ovr |=> overrun_error_flag_ff && $stable(fifo_ff[0])
        && cnt_ff == FIFO_FULL)
        else $error("overrun did not hold FIFO");
    ovr_block_a: assert property (overrun_error_flag_ff |-> !push)
        else $error("character accepted during overrun");
    thr_move_a: assert property (load_wr |=> busy_ff && !thrf_ff
        && tsr_ff == $past(wr_char))
        else $error("write did not reach shifter");
    held_move_a: assert property (tx_done && thrf_ff && tx_mode
        |=> ##1 busy_ff && transmit_buffer_empty_flag)
        else $error("held character not moved");
    ninth_a: assert property (rd_go && ra == ADR_RCSC
        |=> s_axi_rdata[B_RECEIVE_NINTH_BIT_VALUE] == $past(fifo_ff[0][8]))
        else $error("ninth bit status wrong");
endmodule // ssm_top
`default_nettype wire

//--- verif/ssm_peer.sv
// Purpose: Far-side clocked serial device for the serial port bench.
// Assumes: The bench resolves both lines; pol is the clock idle level.
// Notes: Drives data on leading edges and captures it on trailing ones.
`timescale 1ns/1ps
`default_nettype none
module ssm_peer (
    input wire logic sck,
    input wire logic sdl,
    input wire logic pol,
    output logic sdo,
    output logic sdo_oe,
    output logic sck_o,
    output logic sck_oe
);
    logic [8:0] txq[$];
    logic [8:0] rxq[$];
    logic [8:0] tw;
    logic [8:0] rw;
    logic drv;
    int nb;
    int ti;
    int ri;
    int edges;

    // Quiet lines at start; the data pin floats to its pull-up.
    initial begin
        {sdo, sdo_oe, sck_o, sck_oe, drv} = '0;
        tw = '0;
        rw = '0;
        clear(8);
    end

    // Fresh frame state, so stray edges from mode changes never leak over.
    task automatic clear(input int n);
        txq.delete();
        rxq.delete();
        drv = 1'b0;
        sdo_oe = 1'b0;
        nb = n;
        ti = 0;
        ri = 0;
        edges = 0;
    endtask

    // Leading edges launch our next bit, trailing edges capture the line.
    always @(sck) begin
        if (sck === !pol) begin
            edges++;
            if (drv) begin
                if (ti == 0 && txq.size() > 0) tw = txq.pop_front();
                sdo = tw[ti];
                sdo_oe = 1'b1;
                ti = (ti + 1) % nb;
            end
        end else if (sck === pol) begin
            rw[ri] = sdl;
            ri++;
            if (ri == nb) begin
                rxq.push_back(rw);
                ri = 0;
            end
        end
    end

    // One clock per data bit; the clock then stands still at idle.
    task automatic clocks(input int n);
        sck_o = pol;
        sck_oe = 1'b1;
        repeat (n) begin
            #24 sck_o = !pol;
            #24 sck_o = pol;
        end
        #24;
    endtask
endmodule // ssm_peer
`default_nettype wire

//--- verif/tb_top.sv
// Purpose: Self-checking bench for the clocked serial port block.
// Assumes: AXI4-Lite master tasks; the far side is the ssm_peer model.
// Notes: Both lines idle at a bias level when nobody drives them.
`timescale 1ns/1ps
`default_nettype none
module tb_top import ssm_pkg::*;;
    logic aclk, aresetn, pol;
    logic [5:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, wake_o;
    logic data_line_o, data_line_oe, clock_line_o, clock_line_oe;
    logic p_do, p_doe, p_ck, p_ckoe;
    wire dl;
    wire ck;
    int fail_count, n_tests;

    // Whoever enables its driver owns the wire; otherwise the bias wins.
    assign dl = data_line_oe ? data_line_o : (p_doe ? p_do : 1'b1);
    assign ck = clock_line_oe ? clock_line_o : (p_ckoe ? p_ck : pol);

    ssm_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .data_line_i(dl),
        .data_line_o, .data_line_oe, .clock_line_i(ck), .clock_line_o,
        .clock_line_oe, .wake_o);

    ssm_peer peer (.sck(ck), .sdl(dl), .pol(pol), .sdo(p_do),
        .sdo_oe(p_doe), .sck_o(p_ck), .sck_oe(p_ckoe));

    // The system clock.
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = !aclk;
    end

    function automatic logic [31:0] b(input int i);
        return 32'h1 << i;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] e,
        input string m);
        n_tests++;
        if (got !== e) begin
            fail_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, e);
        end
    endtask

    // Ready is judged at the falling edge, so the rising edge that takes
    // the request is the one right after, with no race on comb outputs.
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(negedge aclk); while (!(s_axi_awready === 1'b1 &&
            s_axi_wready === 1'b1));
        @(posedge aclk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        while (s_axi_bvalid !== 1'b1) @(negedge aclk);
        rsp = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (s_axi_arready !== 1'b1);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(negedge aclk);
        rd_v = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask

    task automatic rdc(input logic [5:0] a, input logic [31:0] e,
        input string m);
        rd(a);
        chk(rd_v, e, m);
    endtask

    task automatic t_regs();
        rdc(ADR_IFLG, b(B_TXI), "flags after reset");
        rdc(ADR_RCSC, 32'h0, "receive control after reset");
        rdc(ADR_TXB, 32'h0, "holding buffer reads zero");
        wr(ADR_DIVL, 32'h3);
        rdc(ADR_DIVL, 32'h3, "divisor low");
        // A write with its low byte lane off must leave the register alone.
        s_axi_wstrb <= 4'h0;
        wr(ADR_DIVL, 32'h5);
        s_axi_wstrb <= 4'hf;
        rdc(ADR_DIVL, 32'h3, "masked write ignored");
        wr(6'h28, 32'h1);
        chk(32'(rsp), 32'(RESP_ERR), "unmapped write");
        rd(6'h28);
        chk(32'(rsp), 32'(RESP_ERR), "unmapped read");
        $display("test regs done");
    endtask

    // Two back-to-back characters; the second waits in the holding buffer.
    task automatic t_mtx();
        pol = 1'b1;
        wr(ADR_BAUD, b(B_CLOCK_POLARITY_SELECT));
        wr(ADR_TXSC, b(B_CLOCK_SOURCE_MASTER)|b(B_SYNC)|b(B_HIGH_SPEED_BAUD_SELECT)|b(B_TRANSMIT_ENABLE));
        wr(ADR_RCSC, b(B_SERIAL_PORT_ENABLE));
        peer.clear(8);
        chk(32'({ck, clock_line_oe}), 32'h3, "clock idle high");
        wr(ADR_TXB, 32'ha5);
        wr(ADR_TXB, 32'h3c);
        do rd(ADR_TXSC); while (rd_v[B_TRMT] !== 1'b1 || peer.rxq.size() < 2);
        chk(32'(peer.edges), 32'd16, "one clock per bit");
        chk(32'(peer.rxq[0]), 32'ha5, "first character");
        chk(32'(peer.rxq[1]), 32'h3c, "held character");
        chk(32'(ck), 32'h1, "clock back at idle");
        $display("test master transmit done");
    endtask

    // Single receive of a nine-bit character.
    task automatic t_mrx9();
        pol = 1'b0;
        wr(ADR_BAUD, 32'h0);
        wr(ADR_TXSC, b(B_CLOCK_SOURCE_MASTER)|b(B_SYNC)|b(B_HIGH_SPEED_BAUD_SELECT));
        wr(ADR_RCSC, b(B_SERIAL_PORT_ENABLE)|b(B_RX9));
        peer.clear(9);
        peer.txq.push_back(9'h1c3);
        peer.drv = 1'b1;
        wr(ADR_RCSC, b(B_SERIAL_PORT_ENABLE)|b(B_RX9)|b(B_SINGLE_RECEIVE_ENABLE));
        chk(32'(data_line_oe), 32'h0, "data driver off");
        do rd(ADR_RCSC); while (rd_v[B_SINGLE_RECEIVE_ENABLE] !== 1'b0);
        chk(32'(peer.edges), 32'd9, "nine clocks only");
        rdc(ADR_IFLG, b(B_RXI)|b(B_TXI), "receive flag");
        rdc(ADR_RCSC, b(B_SERIAL_PORT_ENABLE)|b(B_RX9)|b(B_RECEIVE_NINTH_BIT_VALUE), "ninth");
        rdc(ADR_RXT, 32'hc3, "low byte");
        rdc(ADR_IFLG, b(B_TXI), "flag clears when empty");
        $display("test master receive done");
    endtask

    // Continuous receive runs into overrun; both stored bytes survive.
    task automatic t_over();
        int e;
        peer.clear(8);
        peer.txq = '{9'h11, 9'h22, 9'h33, 9'h44};
        peer.drv = 1'b1;
        wr(ADR_RCSC, b(B_SERIAL_PORT_ENABLE)|b(B_SINGLE_RECEIVE_ENABLE)|b(B_CONTINUOUS_RECEIVE_ENABLE));
        do rd(ADR_RCSC); while (rd_v[B_OVERRUN_ERROR_FLAG] !== 1'b1);
        chk(rd_v, b(B_SERIAL_PORT_ENABLE)|b(B_CONTINUOUS_RECEIVE_ENABLE)|b(B_OVERRUN_ERROR_FLAG), "overrun");
        chk(32'(peer.edges), 32'd24, "clocks then stop");
        rdc(ADR_RXT, 32'h11, "oldest kept");
        rdc(ADR_RCSC, b(B_SERIAL_PORT_ENABLE)|b(B_CONTINUOUS_RECEIVE_ENABLE)|b(B_OVERRUN_ERROR_FLAG), "kept");
        rdc(ADR_RXT, 32'h22, "second kept");
        rdc(ADR_IFLG, b(B_TXI), "fifo empty");
        chk(32'(peer.edges), 32'd24, "no receive in overrun");
        wr(ADR_RCSC, b(B_SERIAL_PORT_ENABLE));
        rdc(ADR_RCSC, b(B_SERIAL_PORT_ENABLE), "overrun cleared");
        // Cancel continuous receive a few bits into a character.
        peer.clear(8);
        wr(ADR_RCSC, b(B_SERIAL_PORT_ENABLE)|b(B_CONTINUOUS_RECEIVE_ENABLE));
        repeat (20) @(posedge aclk);
        wr(ADR_RCSC, b(B_SERIAL_PORT_ENABLE));
        e = peer.edges;
        chk(32'(e > 0 && e < 8), 32'h1, "clock cut mid character");
        repeat (40) @(posedge aclk);
        chk(32'(peer.edges), 32'(e), "clock stays stopped");
        chk(32'(ck), 32'h0, "clock at idle after cancel");
        rdc(ADR_IFLG, b(B_TXI), "partial dropped");
        $display("test overrun done");
    endtask

    // Slave transmit: two writes, the far side supplies the clocks.
    task automatic t_stx();
        wr(ADR_RCSC, 32'h0);
        // Nine-bit characters: ninth bit set up before the low byte.
        wr(ADR_TXSC, b(B_SYNC)|b(B_TRANSMIT_ENABLE)|b(B_TX9)|b(B_TRANSMIT_NINTH_BIT_VALUE));
        wr(ADR_RCSC, b(B_SERIAL_PORT_ENABLE));
        wr(ADR_IEN, b(B_TXI));
        wr(ADR_ICTL, b(B_PERIPHERAL_IRQ_ENABLE));
        peer.clear(9);
        chk(32'({clock_line_oe, data_line_oe}), 32'h1, "slave");
        wr(ADR_TXB, 32'h69);
        wr(ADR_TXB, 32'h96);
        rdc(ADR_IFLG, 32'h0, "flag stays clear");
        @(negedge aclk);
        chk(32'(wake_o), 32'h0, "no wake yet");
        peer.clocks(9);
        chk(32'(peer.rxq[0]), 32'h169, "first out");
        rdc(ADR_IFLG, b(B_TXI), "held moved, flag set");
        @(negedge aclk);
        chk(32'(wake_o), 32'h1, "wake raised");
        peer.clocks(9);
        chk(32'(peer.rxq[1]), 32'h196, "second out");
        $display("test slave transmit done");
    endtask

    task automatic end_sim();
        $display("counts: %0d compares, %0d mismatches", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // The whole run needs about a thousand cycles; this limit cuts hangs.
    initial begin
        #300000;
        fail_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        end_sim();
    end

    // Main sequence: reset for four cycles, then each scenario in turn.
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, aresetn} = '0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hf;
        pol = 1'b0;
        fail_count = 0;
        n_tests = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_mtx();
        t_mrx9();
        t_over();
        t_stx();
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
